// >>> clock_source_startup_pkg.sv
// constants, field layout and types for the clock source / start-up control
// assumes a single 125 MHz system clock and a synchronous active-high reset
package clock_source_startup_pkg;

  // ==========================================================================
  // register port geometry
  localparam int unsigned ADDR_W    = 16;   // register address width
  localparam int unsigned DATA_W    = 16;   // register data width
  localparam int unsigned CFG_W     = 14;   // configuration word width

  // ==========================================================================
  // register offsets
  localparam logic [ADDR_W-1:0] CFG_WORD_ADDR = 16'h2007; // configuration word
  localparam logic [ADDR_W-1:0] STATUS_ADDR   = 16'h2008; // start-up status

  // ==========================================================================
  // configuration word layout and erased value
  localparam logic [CFG_W-1:0] CFG_RESET     = 14'h3fff; // erased word, all ones
  localparam logic [CFG_W-1:0] CFG_UNIMP_MSK = 14'h3c00; // bits 13:10 read as 1
  localparam int unsigned OSC_SEL_LSB   = 0;  // oscillator select, 3 bits
  localparam int unsigned OSC_SEL_W     = 3;
  localparam int unsigned WDT_EN_BIT    = 3;  // watchdog enable, kept only
  localparam int unsigned POWERUP_TIMER_EN_BIT   = 4;  // powerup_timer_enable, 0 = on
  localparam int unsigned MASTER_CLEAR_PIN_EN_BIT   = 5;  // master clear pin function
  localparam int unsigned FREQ_SEL_BIT  = 7;  // internal_freq_select, 1 = 8 MHz

  // ==========================================================================
  // status register layout
  localparam int unsigned ST_STATE_LSB  = 0;  // 3-bit start-up state
  localparam int unsigned ST_GATE_BIT   = 3;  // clock gate open
  localparam int unsigned ST_RUN_BIT    = 4;  // execution enabled
  localparam int unsigned ST_INTERNAL_OSCILLATOR_MODE_BIT = 5;  // internal oscillator running
  localparam int unsigned ST_GPIO_BIT   = 6;  // secondary pin free for i/o

  // ==========================================================================
  // oscillator select encodings
  typedef enum logic [2:0] {
    LOW_POWER_CRYSTAL_MODE   = 3'h0,
    STANDARD_CRYSTAL_MODE    = 3'h1,
    HIGH_SPEED_CRYSTAL_MODE  = 3'h2,
    EXTERNAL_CLOCK_MODE      = 3'h3,
    INTERNAL_OSC_IO_MODE     = 3'h4,
    INTERNAL_OSC_CLKOUT_MODE = 3'h5,
    RC_IO_MODE               = 3'h6,
    RC_CLKOUT_MODE           = 3'h7
  } osc_mode_type;

  // start-up sequencer states
  typedef enum logic [2:0] {
    ST_POR     = 3'h0,  // power-on reset active
    ST_POWERUP_TIMER    = 3'h1,  // powerup_timer running
    ST_OST     = 3'h2,  // startup_counter counting oscillations
    ST_WARM    = 3'h3,  // internal oscillator warmup_delay
    ST_RC_WAIT = 3'h4,  // two instruction cycles for rc mode
    ST_RUN     = 3'h5,  // clock stable, executing
    ST_SLEEP   = 3'h6   // halted, waiting for wake
  } startup_state_type;

  // ==========================================================================
  // timing
  localparam int unsigned SYS_CLK_HZ       = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned OST_OSC_COUNT    = 1024;  // oscillations to count
  localparam int unsigned RC_OSC_COUNT     = 8;     // 2 instruction cycles
  localparam int unsigned WARMUP_DELAY_NS  = 2000;  // warmup_delay
  localparam int unsigned WARMUP_CYCLES    =
    (WARMUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_TIMER_MS = 64;    // powerup_timer period
  localparam int unsigned POWERUP_TIMER_CYCLES =
    POWERUP_TIMER_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned INTERNAL_OSCILLATOR_MODE_HI_HZ     = 8_000_000;
  localparam int unsigned INTERNAL_OSCILLATOR_MODE_LO_HZ     = 4_000_000;
  localparam int unsigned DIV_HI           = SYS_CLK_HZ / INTERNAL_OSCILLATOR_MODE_HI_HZ;
  localparam int unsigned DIV_LO           = SYS_CLK_HZ / INTERNAL_OSCILLATOR_MODE_LO_HZ;

endpackage

// >>> osc_pin_sync.sv
// two-flop synchroniser with rising-edge pulse for an asynchronous pin
// assumes the pin toggles well below half the system clock rate
`timescale 1ns/1ps
`default_nettype none

module osc_pin_sync
(
  input  wire logic sys_clk,   // system clock
  input  wire logic srst,      // synchronous reset
  input  wire logic pin_in,    // asynchronous input
  output logic      level_out, // synchronised level
  output logic      rise_out   // one-cycle pulse per rising edge
);

  // ==========================================================================
  // synchroniser stages
  logic meta_reg;   // first stage, read only by the second
  logic sync_reg;   // second stage, safe to use
  logic prev_reg;   // delayed copy for the edge detector

  // shift chain; the first stage feeds nothing but the second
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_out = sync_reg;
  assign rise_out  = sync_reg & ~prev_reg;

endmodule // osc_pin_sync

`default_nettype wire

// >>> startup_delay_counter.sv
// loadable down counter used for every start-up delay
// load and count can be requested in the same cycle; the load then wins
`timescale 1ns/1ps
`default_nettype none

module startup_delay_counter
#(
  parameter int unsigned WIDTH = 24   // counter width
)
(
  input  wire logic             sys_clk,   // system clock
  input  wire logic             srst,      // synchronous reset
  input  wire logic             load,      // load a fresh delay
  input  wire logic [WIDTH-1:0] load_val,  // events to wait for
  input  wire logic             count_en,  // one event seen
  output logic                  done       // level, delay expired
);

  // ==========================================================================
  // counter
  logic [WIDTH-1:0] count_reg;   // events still to go
  logic [WIDTH-1:0] count_next;  // next count

  // hold at zero; load wins over a coincident event
  assign count_next = load                          ? load_val :
                      (count_en && count_reg != '0) ? count_reg - 1'b1 :
                                                      count_reg;

  // counter register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  assign done = (count_reg == '0);

endmodule // startup_delay_counter

`default_nettype wire

// >>> clock_source_startup_control.sv
// clock source selection and oscillator start-up sequencing
// assumes the core obeys run_enable and core_clk_en; pins arrive asynchronously
`timescale 1ns/1ps
`default_nettype none

// Operation
// - crystal modes wait 1024 oscillator edges
// - count starts after powerup timer and wake
// - execution held while start-up count runs
// - source change inserts a stabilisation delay
// - internal oscillator waits warm-up delay
// - external clock drives primary; secondary becomes i/o
// - external-clock mode skips the start-up counter
// - static logic: stopped clock keeps state
// - internal oscillator offers 4 or 8 MHz
// - 3-bit select field picks clock source
// - ec, crystal, rc and internal modes supported
// - 14-bit configuration word at 2007h
// - master clear stops internal/rc oscillator
// - powerup timer after por, counter after timer
module clock_source_startup_control
  import clock_source_startup_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_TIMER_CYCLES, // powerup_timer
  parameter int unsigned CNT_W          = 24                    // delay counter
)
(
  input  wire logic                                 sys_clk,
  input  wire logic                                 srst,
  input  wire logic [clock_source_startup_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [clock_source_startup_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [clock_source_startup_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                                 por_active,
  input  wire logic                                 master_clear_pin_n,
  input  wire logic                                 primary_osc_pin,
  input  wire logic                                 wake_event,
  input  wire logic                                 sleep_req,
  output logic                                      run_enable,
  output logic                                      core_clk_en,
  output logic                                      clk_gate_open,
  output clock_source_startup_pkg::osc_mode_type    clk_source_sel,
  output logic                                      internal_osc_enable,
  output logic                                      internal_freq_8mhz,
  output logic                                      secondary_osc_pin_gpio,
  output logic                                      clkout_enable
);

  import clock_source_startup_pkg::*;

  // ==========================================================================
  // helper functions

  // crystal or resonator modes need the oscillation count
  function automatic logic is_crystal(input osc_mode_type m);
    is_crystal = (m == LOW_POWER_CRYSTAL_MODE) ||
                 (m == STANDARD_CRYSTAL_MODE)  ||
                 (m == HIGH_SPEED_CRYSTAL_MODE);
  endfunction

  // both internal oscillator variants
  function automatic logic is_internal(input osc_mode_type m);
    is_internal = (m == INTERNAL_OSC_IO_MODE) || (m == INTERNAL_OSC_CLKOUT_MODE);
  endfunction

  // both rc variants
  function automatic logic is_rc(input osc_mode_type m);
    is_rc = (m == RC_IO_MODE) || (m == RC_CLKOUT_MODE);
  endfunction

  // state to enter once power-up or wake allows the oscillator delay
  function automatic startup_state_type delay_state(input osc_mode_type m);
    if (is_crystal(m))
      delay_state = ST_OST;
    else if (is_internal(m))
      delay_state = ST_WARM;
    else if (is_rc(m))
      delay_state = ST_RC_WAIT;
    else
      delay_state = ST_RUN;                 // external clock: no delay
  endfunction

  // ==========================================================================
  // declarations
  logic [CFG_W-1:0]     cfg_reg;        // configuration word
  logic [CFG_W-1:0]     cfg_next;       // next configuration word
  osc_mode_type         mode;           // current oscillator select
  osc_mode_type         mode_prev_reg;  // select seen last cycle
  logic                 mode_changed;   // source change detected
  logic                 powerup_timer_enabled;   // powerup_timer_enable cleared
  logic                 master_clear_pin_enabled;   // pin acts as master clear
  logic                 freq_hi;        // 8 MHz internal selection
  logic                 por_sync;       // synchronised power-on reset
  logic                 master_clear_pin_n_sync;    // synchronised master clear, low active
  logic                 wake_sync;      // synchronised wake level
  logic                 osc_rise;       // primary pin rising edge
  logic                 master_clear_pin_hold;      // master clear asserted and enabled
  startup_state_type    state_reg;      // sequencer state
  startup_state_type    state_next;     // next sequencer state
  logic                 cnt_load;       // start a new delay
  logic [CNT_W-1:0]     cnt_load_val;   // length of that delay
  logic                 cnt_en;         // event counted by the delay
  logic                 cnt_done;       // delay expired
  logic [4:0]           div_reg;        // internal oscillator divider
  logic [4:0]           div_next;       // next divider value
  logic [4:0]           div_top;        // divider terminal count
  logic                 int_tick;       // internal oscillator cycle
  logic                 src_tick;       // cycle of the selected source
  logic                 core_clk_en_next;
  logic                 gate_open;      // clock mux enabled
  logic                 hit_cfg;        // address decode, configuration
  logic                 hit_status;     // address decode, status
  logic [DATA_W-1:0]    status_word;    // live status
  logic [DATA_W-1:0]    rdata_next;     // read data for next cycle

  // ==========================================================================
  // pin synchronisers
  osc_pin_sync u_por_sync
  (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .pin_in    (por_active),
    .level_out (por_sync),
    .rise_out  ()
  );

  osc_pin_sync u_master_clear_pin_sync
  (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .pin_in    (master_clear_pin_n),
    .level_out (master_clear_pin_n_sync),
    .rise_out  ()
  );

  osc_pin_sync u_wake_sync
  (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .pin_in    (wake_event),
    .level_out (wake_sync),
    .rise_out  ()
  );

  // primary pin edges count oscillations and clock the external modes
  osc_pin_sync u_osc_sync
  (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .pin_in    (primary_osc_pin),
    .level_out (),
    .rise_out  (osc_rise)
  );

  // ==========================================================================
  // configuration word decode
  assign mode         = osc_mode_type'(cfg_reg[OSC_SEL_LSB +: OSC_SEL_W]);
  assign powerup_timer_enabled = ~cfg_reg[POWERUP_TIMER_EN_BIT];
  assign master_clear_pin_enabled = cfg_reg[MASTER_CLEAR_PIN_EN_BIT];
  assign freq_hi      = cfg_reg[FREQ_SEL_BIT];
  assign master_clear_pin_hold    = master_clear_pin_enabled & ~master_clear_pin_n_sync;
  assign mode_changed = (mode != mode_prev_reg);

  // ==========================================================================
  // register port decode
  assign hit_cfg    = (reg_addr == CFG_WORD_ADDR);
  assign hit_status = (reg_addr == STATUS_ADDR);

  // programming path; unimplemented high bits stay at one
  assign cfg_next = (reg_wr && hit_cfg) ?
                    (reg_wdata[CFG_W-1:0] | CFG_UNIMP_MSK) : cfg_reg;

  // status word shows the sequencer's own state
  assign status_word = {9'h000,
                        secondary_osc_pin_gpio,
                        internal_osc_enable,
                        run_enable,
                        gate_open,
                        state_reg};

  // unmapped reads return zero
  assign rdata_next = !reg_rd   ? '0 :
                      hit_cfg    ? {{(DATA_W-CFG_W){1'b0}}, cfg_reg} :
                      hit_status ? status_word :
                                   '0;

  // configuration and read data registers
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cfg_reg       <= CFG_RESET;
      reg_rdata     <= '0;
      mode_prev_reg <= osc_mode_type'(CFG_RESET[OSC_SEL_LSB +: OSC_SEL_W]);
    end
    else
    begin
      cfg_reg       <= cfg_next;
      reg_rdata     <= rdata_next;
      mode_prev_reg <= mode;
    end
  end

  // ==========================================================================
  // start-up sequencer, next state
  // por overrides everything; a source change restarts the oscillator delay
  always_comb
  begin
    state_next = state_reg;
    if (por_sync)
      state_next = ST_POR;
    else if (mode_changed && state_reg != ST_POR && state_reg != ST_POWERUP_TIMER)
      state_next = delay_state(mode);
    else
    begin
      case (state_reg)
        ST_POR:
        begin
          // timer starts only once por has ended
          if (powerup_timer_enabled)
            state_next = ST_POWERUP_TIMER;
          else
            state_next = delay_state(mode);
        end
        ST_POWERUP_TIMER:
        begin
          // counter starts only after the timer expires
          if (cnt_done)
            state_next = delay_state(mode);
        end
        ST_OST, ST_WARM, ST_RC_WAIT:
        begin
          if (cnt_done)
            state_next = ST_RUN;
        end
        ST_RUN:
        begin
          if (sleep_req)
            state_next = ST_SLEEP;
        end
        ST_SLEEP:
        begin
          // every wake repeats the oscillator delay
          if (wake_sync)
            state_next = delay_state(mode);
        end
        default:
          state_next = ST_POR;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      state_reg <= ST_POR;
    else
      state_reg <= state_next;
  end

  // ==========================================================================
  // delay counter steering
  // load on entry into any delay state
  // a source change during the powerup_timer must not restart the timer
  assign cnt_load = (state_next != state_reg ||
                     (mode_changed && !por_sync && state_reg != ST_POWERUP_TIMER)) &&
                    (state_next == ST_POWERUP_TIMER || state_next == ST_OST ||
                     state_next == ST_WARM || state_next == ST_RC_WAIT);

  // length of the delay being entered
  assign cnt_load_val = (state_next == ST_POWERUP_TIMER) ? CNT_W'(POWERUP_CYCLES) :
                        (state_next == ST_OST)  ? CNT_W'(OST_OSC_COUNT) :
                        (state_next == ST_WARM) ? CNT_W'(WARMUP_CYCLES) :
                                                  CNT_W'(RC_OSC_COUNT);

  // timer and warm-up count system cycles; others count oscillations
  assign cnt_en = (state_reg == ST_POWERUP_TIMER || state_reg == ST_WARM) ? 1'b1 :
                  (state_reg == ST_OST)                          ? osc_rise :
                  (state_reg == ST_RC_WAIT)                      ? osc_rise :
                                                                   1'b0;

  startup_delay_counter
  #(
    .WIDTH    (CNT_W)
  )
  u_delay
  (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .load     (cnt_load),
    .load_val (cnt_load_val),
    .count_en (cnt_en),
    .done     (cnt_done)
  );

  // ==========================================================================
  // internal oscillator model
  // stopped by master clear in internal and rc modes, and in sleep
  assign internal_osc_enable = is_internal(mode) && state_reg != ST_SLEEP &&
                               !(master_clear_pin_hold && (is_internal(mode) || is_rc(mode)));

  // divider approximates 4 or 8 MHz from the 125 MHz clock;
  // integer division leaves a small frequency error, accepted
  assign div_top  = freq_hi ? 5'(DIV_HI - 1) : 5'(DIV_LO - 1);
  assign int_tick = internal_osc_enable && (div_reg == 5'h00);
  assign div_next = !internal_osc_enable ? div_top :
                    (div_reg == 5'h00)   ? div_top :
                                           div_reg - 5'h01;

  // divider register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      div_reg <= 5'h00;
    else
      div_reg <= div_next;
  end

  // ==========================================================================
  // clock multiplexer and gate
  // internal modes take the divider tick; every other mode takes the primary pin
  assign src_tick  = is_internal(mode) ? int_tick : osc_rise;
  assign gate_open = (state_reg == ST_RUN);

  // no enable is produced while the gate is shut or the source is silent,
  // so every core register simply holds its value
  assign core_clk_en_next = gate_open && src_tick && !master_clear_pin_hold;

  // registered clock enable and gate flag
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      core_clk_en   <= 1'b0;
      clk_gate_open <= 1'b0;
    end
    else
    begin
      core_clk_en   <= core_clk_en_next;
      clk_gate_open <= gate_open;
    end
  end

  // ==========================================================================
  // outputs to the core and pin muxes
  // program counter frozen outside run and during master clear
  assign run_enable         = gate_open && !master_clear_pin_hold;
  assign clk_source_sel     = mode;
  assign internal_freq_8mhz = freq_hi;

  // secondary pin is plain i/o where no crystal or clock-out uses it
  assign secondary_osc_pin_gpio = (mode == EXTERNAL_CLOCK_MODE) ||
                                  (mode == INTERNAL_OSC_IO_MODE) ||
                                  (mode == RC_IO_MODE);
  assign clkout_enable          = (mode == INTERNAL_OSC_CLKOUT_MODE) ||
                                  (mode == RC_CLKOUT_MODE);

endmodule // clock_source_startup_control

`default_nettype wire

// >>> clock_source_startup_checker.sv
// port assertions for the clock source start-up control
// assumes a bind onto the top module and one clock domain
`timescale 1ns/1ps
`default_nettype none
module clock_source_startup_checker
  import clock_source_startup_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         srst,
  input wire logic  [15:0] reg_addr,
  input wire logic  [15:0] reg_wdata,
  input wire logic         reg_wr,
  input wire logic         reg_rd,
  input wire logic  [15:0] reg_rdata,
  input wire logic         run_enable,
  input wire logic         core_clk_en,
  input wire logic         clk_gate_open,
  input wire osc_mode_type clk_source_sel,
  input wire logic         internal_freq_8mhz,
  input wire logic         secondary_osc_pin_gpio,
  input wire logic         clkout_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // register port and mode decode
  rdata_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data outside its slot");
  cfg_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 16'h2007
    |-> reg_rdata[15:10] == 6'h0f) else $error("config upper bits wrong");
  cfg_apply_a: assert property ($past(reg_wr) && $past(reg_addr) == 16'h2007
    |-> clk_source_sel == 3'($past(reg_wdata)) && internal_freq_8mhz == $past(reg_wdata[7]))
    else $error("config write not applied");
  gpio_mode_a: assert property (secondary_osc_pin_gpio ==
    (clk_source_sel inside {3'h3, 3'h4, 3'h6})) else $error("gpio pin mode wrong");
  clkout_mode_a: assert property (clkout_enable ==
    (clk_source_sel inside {3'h5, 3'h7})) else $error("clock out mode wrong");
  // ==========================================================
  // gating of execution
  mode_restart_a: assert property ($changed(clk_source_sel) && $past(run_enable)
    && clk_source_sel != EXTERNAL_CLOCK_MODE |=> !run_enable) else $error("switch not held");
  run_gate_a: assert property (run_enable |=> clk_gate_open)
    else $error("gate shut while running");
  tick_gated_a: assert property (core_clk_en |-> clk_gate_open)
    else $error("core tick with gate shut");
endmodule // clock_source_startup_checker
bind clock_source_startup_control clock_source_startup_checker u_clock_source_startup_checker (.*);
`default_nettype wire

// >>> osc_source_model.sv
// logic-level oscillator source on the primary pin
// assumes the bench sets the half period in ns; rests low when stopped
`timescale 1ns/1ps
`default_nettype none
module osc_source_model
(
  input  wire logic        osc_run, // oscillate while high
  input  wire logic [15:0] half_ns, // half period, slow or prompt
  output logic             osc_pin  // clock into the pin
);
  initial osc_pin = 1'b0;
  // a stopped source stands still low, never floats
  always #(half_ns) osc_pin = osc_run & ~osc_pin;
endmodule // osc_source_model
`default_nettype wire

// >>> clock_source_startup_control_test.sv
// self-checking bench for clock source start-up control
// assumes design, oscillator model and checker compile first
`timescale 1ns/1ps
`default_nettype none
module clock_source_startup_control_test;
  import clock_source_startup_pkg::*;
  localparam int PWR = 20; // short powerup_timer keeps the run brief
  logic sys_clk = 1'b0;
  logic srst, reg_wr, reg_rd, por_active, master_clear_pin_n, wake_event, sleep_req;
  logic primary_osc_pin, osc_run, run_enable, core_clk_en, clk_gate_open;
  logic internal_osc_enable, internal_freq_8mhz, secondary_osc_pin_gpio, clkout_enable;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, rdv;
  logic [15:0] half_ns = 16'd36;
  osc_mode_type clk_source_sel;
  int miscompares, checks, seed, edges, ticks, cyc, edg, n;
  clock_source_startup_control #(.POWERUP_CYCLES(PWR)) u_clock_source_startup_control (.*);
  osc_source_model u_osc_source_model (.osc_run, .half_ns, .osc_pin(primary_osc_pin));
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge primary_osc_pin) edges++;
  always @(posedge sys_clk) ticks += int'(core_clk_en);
  initial #780000 summarize(1); // hang guard, about 97k cycles
  // =========================================================
  // helpers
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp)
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    miscompares += int'(seen !== exp);
  endtask
  // one register cycle; read data taken in the slot after the strobe
  task automatic bus(input logic w, input logic [15:0] a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= ~w;
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'b00;
    @(posedge sys_clk);
    rdv = reg_rdata;
  endtask
  task automatic wait_run;
    n = edges;
    @(posedge sys_clk); // a request just taken must reach the state first
    for (cyc = 1; run_enable !== 1'b1 && cyc < 20000; cyc++) @(posedge sys_clk);
    edg = edges - n;
  endtask
  // edges for crystal and rc, system cycles otherwise
  function automatic int exp_delay(input logic [2:0] m, input logic pw);
    return m < 3 ? OST_OSC_COUNT : m > 5 ? RC_OSC_COUNT : m > 3 ? WARMUP_CYCLES : pw ? PWR : 0;
  endfunction
  task automatic boot(input logic [2:0] m, input logic pw);
    logic [7:0] lo;
    lo = {1'($random(seed)), 2'b11, ~pw, 1'b1, m};
    bus(1'b1, CFG_WORD_ADDR, {8'h3f, lo});
    bus(1'b0, CFG_WORD_ADDR, 16'h0);
    chk("config", rdv, {8'h3f, lo});
    por_active <= 1'b1;
    repeat (3) @(posedge sys_clk);
    por_active <= 1'b0;
    wait_run;
    n = exp_delay(m, pw);
    if (m < 3 || m > 5)
      chk("osc edges", 16'(edg >= n && edg <= n + 2), 16'h1);
    else
      chk("delay", 16'(cyc >= n && cyc <= n + 8), 16'h1);
    chk("freq", 16'(internal_freq_8mhz), 16'(lo[7]));
  endtask
  task automatic summarize(input int t);
    miscompares += t;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // =========================================================
  // scenarios
  initial
  begin
    seed = 32'h224a;
    {srst, reg_wr, reg_rd, por_active, wake_event, sleep_req} = 6'b100000;
    {master_clear_pin_n, osc_run, reg_addr, reg_wdata} = {2'b11, 32'h0};
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    bus(1'b0, CFG_WORD_ADDR, 16'h0);
    chk("erased", rdv, 16'h3fff);
    bus(1'b0, 16'h0000, 16'h0);
    chk("unmapped", rdv, 16'h0);
    for (int m = 0; m < 9; m++)
    begin
      half_ns <= 16'd24 + 16'($random(seed) & 32'h1f);
      boot(3'(m + 3), m == 8);
    end
    // a stopped external clock freezes the core, state kept
    osc_run <= 1'b0;
    repeat (6) @(posedge sys_clk); // let a rise already in the synchroniser drain
    n = ticks;
    repeat (40) @(posedge sys_clk);
    chk("stopped", 16'(ticks - n), 16'h0);
    osc_run <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk("resumed", {15'h0, ticks > n && run_enable === 1'b1}, 16'h1);
    bus(1'b1, CFG_WORD_ADDR, 16'h3ffc);
    wait_run;
    chk("to internal_oscillator_mode", 16'(cyc + 4 >= WARMUP_CYCLES && cyc <= WARMUP_CYCLES + 6), 16'h1);
    master_clear_pin_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("clear held", {14'h0, run_enable, internal_osc_enable}, 16'h0);
    master_clear_pin_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("clear released", 16'(run_enable), 16'h1);
    bus(1'b1, CFG_WORD_ADDR, 16'h3ffa);
    wait_run;
    chk("to crystal", 16'(edg + 1 >= OST_OSC_COUNT && edg <= OST_OSC_COUNT + 2), 16'h1);
    sleep_req <= 1'b1;
    @(posedge sys_clk);
    sleep_req <= 1'b0;
    bus(1'b0, STATUS_ADDR, 16'h0);
    chk("asleep", rdv & 16'h1f, 16'h06);
    wake_event <= 1'b1;
    wait_run;
    wake_event <= 1'b0;
    chk("wake", 16'(edg >= OST_OSC_COUNT && edg <= OST_OSC_COUNT + 2), 16'h1);
    summarize(0);
  end
endmodule // clock_source_startup_control_test
`default_nettype wire
